// >>> common/scr_pkg.sv
package scr_pkg;
   // ----------------------------------------------------------------
   // word layout
   // ----------------------------------------------------------------
   localparam int unsigned WORD_W = 24;
   localparam logic [1:0] ADDR_MAIN = 2'h0;
   localparam logic [1:0] ADDR_CTRL = 2'h1;
   localparam logic [1:0] ADDR_PUMP = 2'h2;
   localparam logic [2:0] ADDR_BW = 3'h3;
   // main word fields
   localparam int unsigned POS_DEF = 23;
   localparam int unsigned POS_BAND = 22;
   localparam int unsigned POS_LD = 21;
   localparam int unsigned POS_SPURC = 20;
   localparam int unsigned POS_PCNT = 16;
   localparam int unsigned POS_SWAL = 13;
   localparam int unsigned POS_FRAC = 2;
   // control word fields
   localparam int unsigned POS_IFSEL = 22;
   localparam int unsigned POS_REF = 21;
   localparam int unsigned POS_SPUR = 11;
   localparam int unsigned POS_PWR = 4;
   localparam int unsigned POS_RFEN = 3;
   localparam int unsigned POS_IFEN = 2;
   // pump and bandwidth fields
   localparam int unsigned POS_PUMP = 22;
   localparam int unsigned POS_BDUR = 22;
   localparam int unsigned POS_BCRIT = 20;
   localparam int unsigned POS_BEN = 19;
   localparam int unsigned POS_VCO = 3;
   // defaults: the fixed bits of each word, every field cleared
   localparam logic [23:0] RST_MAIN = 24'h000000;
   localparam logic [23:0] RST_CTRL = 24'h100141;
   localparam logic [23:0] RST_PUMP = 24'h09DA8A;
   localparam logic [23:0] RST_BW = 24'h05E8C3;
   // spur modes and prescalers
   localparam logic [1:0] SPUR_OFF = 2'h0;
   localparam logic [1:0] SPUR_TRACK = 2'h2;
   localparam logic [1:0] SPUR_ONCE = 2'h3;
   localparam logic [3:0] PRESC_HI = 4'h8;
   localparam logic [3:0] PRESC_LO = 4'h6;
   // bandwidth controller duration per code, in reference ticks
   localparam logic [7:0] BW_TICKS0 = 8'h10;
   localparam logic [7:0] BW_STEP = 8'h20;
endpackage : scr_pkg

// >>> hw/scr_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for pin inputs
module scr_sync (
   input wire logic i_clk, // system clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic i_d, // asynchronous input
   output logic o_q // synchronised level
);
   logic meta;
   // ------------------------------------------------------------
   // meta only feeds o_q, never other logic
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta <= 1'b0;
         o_q <= 1'b0;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule : scr_sync

// >>> hw/scr_top.sv
`timescale 1ns/10ps
// serial configuration bank of the synthesizer
module scr_top #(
   parameter bit VARIANT_B = 1'b0 // 0: first variant, 1: second variant
) (
   input wire logic i_clk, // 100 MHz system clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic i_ser_clk, // serial clock pin
   input wire logic i_ser_data, // serial data pin
   input wire logic i_latch_enable, // latch enable pin
   input wire logic i_chip_enable, // chip enable pin, low powers down
   input wire logic i_ref_tick, // reference tick, same domain
   input wire logic i_locked, // loop lock flag, same domain
   input wire logic i_phase_ok, // phase offset within criterion
   output logic [23:0] o_main_rf_divider_word, // main RF word
   output logic [23:0] o_synth_enable_config, // control word
   output logic [23:0] o_if_pump_current, // pump word
   output logic [23:0] o_lock_bandwidth_control, // bandwidth word
   output logic o_gps_mode, // band select resolves to GPS
   output logic [3:0] o_prescaler, // prescaler for active band
   output logic [7:0] o_n_integer, // prescaler*count+swallow
   output logic [10:0] o_fractional_numerator, // fraction
   output logic o_default_values_select, // built-in IF counters
   output logic [1:0] o_if_default_select, // IF frequency code
   output logic o_reference_select, // 0: 19.20, 1: 19.68 MHz
   output logic [1:0] o_output_power_level, // buffer level code
   output logic [1:0] o_if_pump_current_sel, // pump current code
   output logic [1:0] o_vco_dynamic_current, // VCO current code
   output logic [1:0] o_phase_offset_criterion, // criterion code
   output logic o_rf_on, // RF loop powered
   output logic o_if_on, // IF loop powered
   output logic o_spur_track, // spur compensation updating
   output logic o_bw_active // bandwidth controller acting
);
   import scr_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic sclk_s;
   logic sdat_s;
   logic le_s;
   logic ce_s;
   scr_sync u_sclk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_ser_clk), .o_q(sclk_s));
   scr_sync u_sdat (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_ser_data), .o_q(sdat_s));
   scr_sync u_le (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_latch_enable), .o_q(le_s));
   scr_sync u_ce (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_chip_enable), .o_q(ce_s));

   // ------------------------------------------------------------
   // edge detection on synchronised pins
   // ------------------------------------------------------------
   logic sclk_d;
   logic le_d;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sclk_d <= 1'b0;
         le_d <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
         le_d <= le_s;
      end
   end
   logic sclk_rise;
   logic le_rise;
   assign sclk_rise = sclk_s & ~sclk_d;
   assign le_rise = le_s & ~le_d;

   // ------------------------------------------------------------
   // shift register, msb first; data and clock share delay
   // ------------------------------------------------------------
   logic [23:0] shreg;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shreg <= 24'h000000;
      end else if (sclk_rise && !le_s) begin
         shreg <= {shreg[22:0], sdat_s};
      end
   end

   // ------------------------------------------------------------
   // address decode; 3-bit and 2-bit codes compared in parallel, no priority
   // ------------------------------------------------------------
   logic hit_main;
   logic hit_ctrl;
   logic hit_pump;
   logic hit_bw;
   assign hit_bw = le_rise && (shreg[2:0] == ADDR_BW);
   assign hit_main = le_rise && (shreg[1:0] == ADDR_MAIN);
   assign hit_ctrl = le_rise && (shreg[1:0] == ADDR_CTRL);
   assign hit_pump = le_rise && (shreg[1:0] == ADDR_PUMP);

   // ------------------------------------------------------------
   // word registers, loaded on latch enable rise
   // ------------------------------------------------------------
   logic [23:0] main_rf_divider_word;
   logic [23:0] synth_enable_config;
   logic [23:0] if_pump_current;
   logic [23:0] lock_bandwidth_control;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         main_rf_divider_word <= RST_MAIN;
      end else if (hit_main) begin
         main_rf_divider_word <= shreg;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         synth_enable_config <= RST_CTRL;
      end else if (hit_ctrl) begin
         synth_enable_config <= shreg;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         if_pump_current <= RST_PUMP;
      end else if (hit_pump) begin
         if_pump_current <= shreg;
      end
   end
   // other words ending in 11 (longer addresses) are ignored here
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lock_bandwidth_control <= RST_BW;
      end else if (hit_bw) begin
         lock_bandwidth_control <= shreg;
      end
   end

   // ------------------------------------------------------------
   // field extraction
   // ------------------------------------------------------------
   logic band_select;
   logic [3:0] rf_programmable_count;
   logic [2:0] rf_swallow_count;
   logic [1:0] spur_reduction_mode;
   logic [1:0] bandwidth_duration;
   logic bandwidth_ctrl_enable;
   assign band_select = main_rf_divider_word[POS_BAND];
   assign rf_programmable_count = main_rf_divider_word[POS_PCNT +: 4];
   assign rf_swallow_count = main_rf_divider_word[POS_SWAL +: 3];
   assign spur_reduction_mode = synth_enable_config[POS_SPUR +: 2];
   assign bandwidth_duration = lock_bandwidth_control[POS_BDUR +: 2];
   assign bandwidth_ctrl_enable = lock_bandwidth_control[POS_BEN];

   // ------------------------------------------------------------
   // band and prescaler resolution per variant
   // ------------------------------------------------------------
   logic gps;
   logic [3:0] presc;
   assign gps = VARIANT_B ? band_select : ~band_select;
   assign presc = (gps ^ VARIANT_B) ? PRESC_LO : PRESC_HI;

   // ------------------------------------------------------------
   // registered divider outputs; ranges are the host's duty
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_gps_mode <= 1'b0;
         o_prescaler <= 4'h0;
         o_n_integer <= 8'h00;
         o_fractional_numerator <= 11'h000;
      end else begin
         o_gps_mode <= gps;
         o_prescaler <= presc;
         o_n_integer <= 8'(presc) * 8'(rf_programmable_count) + 8'(rf_swallow_count);
         o_fractional_numerator <= main_rf_divider_word[POS_FRAC +: 11];
      end
   end

   // ------------------------------------------------------------
   // field outputs and power; chip enable overrides bits
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_default_values_select <= 1'b0;
         o_if_default_select <= 2'h0;
         o_reference_select <= 1'b0;
         o_output_power_level <= 2'h0;
         o_if_pump_current_sel <= 2'h0;
         o_vco_dynamic_current <= 2'h0;
         o_phase_offset_criterion <= 2'h0;
         o_rf_on <= 1'b0;
         o_if_on <= 1'b0;
      end else begin
         o_default_values_select <= main_rf_divider_word[POS_DEF];
         o_if_default_select <= synth_enable_config[POS_IFSEL +: 2];
         o_reference_select <= synth_enable_config[POS_REF];
         o_output_power_level <= synth_enable_config[POS_PWR +: 2];
         o_if_pump_current_sel <= if_pump_current[POS_PUMP +: 2];
         o_vco_dynamic_current <= lock_bandwidth_control[POS_VCO +: 2];
         o_phase_offset_criterion <= lock_bandwidth_control[POS_BCRIT +: 2];
         o_rf_on <= ce_s & synth_enable_config[POS_RFEN];
         o_if_on <= ce_s & synth_enable_config[POS_IFEN];
      end
   end

   // ------------------------------------------------------------
   // spur compensation: one-time mode freezes after lock entry
   // ------------------------------------------------------------
   logic lock_d;
   logic frozen;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lock_d <= 1'b0;
         frozen <= 1'b0;
      end else begin
         lock_d <= i_locked;
         if (spur_reduction_mode != SPUR_ONCE || !o_rf_on) begin
            frozen <= 1'b0;
         end else if (i_locked && !lock_d) begin
            frozen <= 1'b1;
         end
      end
   end
   // mode 01 is unused and treated as off
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_spur_track <= 1'b0;
      end else begin
         case (spur_reduction_mode)
            SPUR_TRACK: o_spur_track <= o_rf_on;
            SPUR_ONCE: o_spur_track <= o_rf_on & ~frozen;
            default: o_spur_track <= 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // bandwidth controller state machine
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      BW_IDLE = 2'b00,
      BW_RUN = 2'b01,
      BW_DONE = 2'b10
   } scr_bw_t;
   scr_bw_t bw_state;
   logic [7:0] bw_cnt;
   logic [7:0] bw_limit;
   // longer duration code gives a longer run; a trade for a simple table
   assign bw_limit = BW_TICKS0 + 8'(bandwidth_duration) * BW_STEP;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bw_state <= BW_IDLE;
         bw_cnt <= 8'h00;
      end else begin
         case (bw_state)
            BW_IDLE: begin
               bw_cnt <= 8'h00;
               if (bandwidth_ctrl_enable && o_rf_on && !i_locked) begin
                  bw_state <= BW_RUN;
               end
            end
            BW_RUN: begin
               if (!bandwidth_ctrl_enable || !o_rf_on) begin
                  bw_state <= BW_IDLE;
               end else if (i_phase_ok || bw_cnt >= bw_limit) begin
                  bw_state <= BW_DONE;
               end else if (i_ref_tick) begin
                  bw_cnt <= bw_cnt + 8'h01;
               end
            end
            BW_DONE: begin
               if (!bandwidth_ctrl_enable || !o_rf_on || hit_main) begin
                  bw_state <= BW_IDLE;
               end
            end
            default: bw_state <= BW_IDLE;
         endcase
      end
   end
   assign o_bw_active = (bw_state == BW_RUN);

   // ------------------------------------------------------------
   // word outputs
   // ------------------------------------------------------------
   assign o_main_rf_divider_word = main_rf_divider_word;
   assign o_synth_enable_config = synth_enable_config;
   assign o_if_pump_current = if_pump_current;
   assign o_lock_bandwidth_control = lock_bandwidth_control;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_latch;
      le_rise;
   endsequence
   chk_ctrl_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_latch ##0 (shreg[1:0] == ADDR_CTRL) |=> synth_enable_config == $past(shreg))
      else $error("control word not loaded");
   chk_pump_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_latch ##0 (shreg[1:0] == ADDR_PUMP) |=> if_pump_current == $past(shreg))
      else $error("pump word not loaded");
   chk_bw_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_latch ##0 (shreg[2:0] == ADDR_BW) |=> lock_bandwidth_control == $past(shreg))
      else $error("bandwidth word not loaded");
   chk_main_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_latch ##0 (shreg[1:0] == ADDR_MAIN) |=> main_rf_divider_word == $past(shreg))
      else $error("main word not loaded");
   chk_shift_msb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      sclk_rise && !le_s |=> shreg[0] == $past(sdat_s) && shreg[23:1] == $past(shreg[22:0]))
      else $error("shift order wrong");
   chk_word_stable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !le_rise |=> $stable(synth_enable_config))
      else $error("word changed without latch");
   chk_chip_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !ce_s |=> !o_rf_on && !o_if_on)
      else $error("loop on while chip disabled");
   chk_presc_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      1'b1 |=> o_prescaler == ((($past(gps)) ^ VARIANT_B) ? PRESC_LO : PRESC_HI))
      else $error("prescaler mapping wrong");
   chk_bw_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !bandwidth_ctrl_enable |=> !o_bw_active)
      else $error("bandwidth controller active while disabled");
   chk_spur_frz: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      frozen && spur_reduction_mode == SPUR_ONCE && $stable(spur_reduction_mode)
      |=> !o_spur_track)
      else $error("spur tracking after freeze");
   chk_spur_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      spur_reduction_mode == SPUR_OFF |=> !o_spur_track)
      else $error("spur tracking while off");
   // every condition for a bandwidth run holds while the controller idles
   sequence s_bw_ready;
      bw_state == BW_IDLE && bandwidth_ctrl_enable && o_rf_on && !i_locked;
   endsequence
   chk_bw_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_bw_ready |=> o_bw_active)
      else $error("bandwidth controller did not start");
   chk_bw_stop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_bw_active && i_phase_ok |=> !o_bw_active)
      else $error("bandwidth controller ran past the criterion");
   chk_bw_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_bw_active && bw_cnt >= bw_limit |=> !o_bw_active)
      else $error("bandwidth run longer than its duration");
   chk_band_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      1'b1 |=> o_gps_mode == (VARIANT_B ? $past(band_select) : !$past(band_select)))
      else $error("band select mapping wrong");
   chk_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      le_s |=> $stable(shreg))
      else $error("shift while latch high");
   chk_rf_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ce_s && synth_enable_config[POS_RFEN] |=> o_rf_on)
      else $error("RF loop off although enabled");
   chk_if_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ce_s && synth_enable_config[POS_IFEN] |=> o_if_on)
      else $error("IF loop off although enabled");
endmodule : scr_top

// >>> verification/scr_host.sv
`timescale 1ns/10ps
// host side of the three-wire port: clock idles low between frames
module scr_host (
   input wire logic i_clk, // system clock
   output logic o_ser_clk, // serial clock, still outside frames
   output logic o_ser_data, // serial data
   output logic o_latch_enable // latch pin
);
   initial begin
      o_ser_clk = 1'b0;
      o_ser_data = 1'b0;
      o_latch_enable = 1'b0;
   end
   // ----------------------------------------------------------------
   // one word: 80 ns low with data set, 80 ns high, then latch
   // ----------------------------------------------------------------
   task automatic send_word(input logic [23:0] w);
      for (int k = 23; k >= 0; k--) begin // msb first
         o_ser_data <= w[k]; // moves with the falling clock, 80 ns before the rise
         repeat (8) @(posedge i_clk);
         o_ser_clk <= 1'b1;
         repeat (8) @(posedge i_clk);
         o_ser_clk <= 1'b0;
      end
      @(posedge i_clk);
      o_latch_enable <= 1'b1; // transfer after the full word
      o_ser_data <= ~w[0]; // released line must not echo the last bit
      repeat (8) @(posedge i_clk);
      o_latch_enable <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask : send_word
endmodule : scr_host

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_top;
   import scr_pkg::*;
   logic i_clk, i_rst_n, i_chip_enable, i_ref_tick, i_locked, i_phase_ok;
   logic ser_clk, ser_data, latch_en, gps, def_sel, ref_sel, rf_on, if_on, spur_tr, bw_act;
   logic gps_b;
   logic [23:0] main_w, ctrl_w, pump_w, bw_w, w;
   logic [3:0] presc, presc_b;
   logic [7:0] n_int, n_int_b;
   logic [10:0] frac;
   logic [1:0] if_sel, pwr, pump_sel, vco_dynamic_current, crit, tick_cnt;
   int fail_count = 0;
   int compares = 0;
   int t;
   scr_host scr_host_i (.i_clk(i_clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data),
      .o_latch_enable(latch_en));
   scr_top #(.VARIANT_B(1'b0)) scr_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_ser_clk(ser_clk), .i_ser_data(ser_data), .i_latch_enable(latch_en),
      .i_chip_enable(i_chip_enable), .i_ref_tick(i_ref_tick), .i_locked(i_locked),
      .i_phase_ok(i_phase_ok), .o_main_rf_divider_word(main_w), .o_synth_enable_config(ctrl_w),
      .o_if_pump_current(pump_w), .o_lock_bandwidth_control(bw_w), .o_gps_mode(gps),
      .o_prescaler(presc), .o_n_integer(n_int), .o_fractional_numerator(frac),
      .o_default_values_select(def_sel), .o_if_default_select(if_sel),
      .o_reference_select(ref_sel), .o_output_power_level(pwr),
      .o_if_pump_current_sel(pump_sel), .o_vco_dynamic_current(vco_dynamic_current),
      .o_phase_offset_criterion(crit), .o_rf_on(rf_on), .o_if_on(if_on),
      .o_spur_track(spur_tr), .o_bw_active(bw_act));
   // second variant shares the pins; only its band and divider outputs are watched
   scr_top #(.VARIANT_B(1'b1)) scr_top_b_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_ser_clk(ser_clk), .i_ser_data(ser_data), .i_latch_enable(latch_en),
      .i_chip_enable(i_chip_enable), .i_ref_tick(i_ref_tick), .i_locked(i_locked),
      .i_phase_ok(i_phase_ok), .o_main_rf_divider_word(), .o_synth_enable_config(),
      .o_if_pump_current(), .o_lock_bandwidth_control(), .o_gps_mode(gps_b),
      .o_prescaler(presc_b), .o_n_integer(n_int_b), .o_fractional_numerator(),
      .o_default_values_select(), .o_if_default_select(), .o_reference_select(),
      .o_output_power_level(), .o_if_pump_current_sel(), .o_vco_dynamic_current(),
      .o_phase_offset_criterion(), .o_rf_on(), .o_if_on(), .o_spur_track(), .o_bw_active());
   // ----------------------------------------------------------------
   // clock, reference tick every fourth cycle
   // ----------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         tick_cnt <= 2'h0;
         i_ref_tick <= 1'b0;
      end else begin
         tick_cnt <= tick_cnt + 2'h1;
         i_ref_tick <= (tick_cnt == 2'h3);
      end
   end
   task automatic conclude();
      $display("errors %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   // send a word and let the sync, load and derived stages settle
   task automatic wr(input logic [23:0] v);
      scr_host_i.send_word(v);
      repeat (8) @(posedge i_clk);
   endtask : wr
   function automatic logic [23:0] mk_ctrl(input logic [1:0] ifs, input logic rs,
      input logic [1:0] sp, input logic [1:0] pw, input logic re, input logic ie);
      logic [23:0] r;
      r = RST_CTRL;
      r[POS_IFSEL +: 2] = ifs;
      r[POS_REF] = rs;
      r[POS_SPUR +: 2] = sp;
      r[POS_PWR +: 2] = pw;
      r[POS_RFEN] = re;
      r[POS_IFEN] = ie;
      return r;
   endfunction : mk_ctrl
   function automatic logic [23:0] mk_bw(input logic [1:0] d, input logic [1:0] c,
      input logic en, input logic [1:0] v);
      logic [23:0] r;
      r = RST_BW;
      r[POS_BDUR +: 2] = d;
      r[POS_BCRIT +: 2] = c;
      r[POS_BEN] = en;
      r[POS_VCO +: 2] = v;
      return r;
   endfunction : mk_bw
   // a hang anywhere ends the run as a failure
   initial begin
      #400us;
      fail_count++;
      conclude();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      i_rst_n = 1'b0;
      i_chip_enable = 1'b1;
      i_locked = 1'b0;
      i_phase_ok = 1'b0;
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      `CHK("main", RST_MAIN, main_w)
      `CHK("ctrl", RST_CTRL, ctrl_w)
      `CHK("pump", RST_PUMP, pump_w)
      `CHK("bw", RST_BW, bw_w)
      // host keeps count 2..15, swallow within prescaler, fraction in range
      for (int b = 1; b >= 0; b--) begin
         w = b ? {1'b1, 1'b1, 2'b00, 4'hF, 3'h7, 11'h77F, 2'b00}
               : {1'b0, 1'b0, 2'b00, 4'h2, 3'h1, 11'h6AF, 2'b00};
         wr(w);
         `CHK("main", w, main_w)
         `CHK("gps", (b == 0), gps)
         `CHK("presc", b ? PRESC_HI : PRESC_LO, presc)
         `CHK("gps_b", (b == 1), gps_b)
         `CHK("presc_b", b ? PRESC_HI : PRESC_LO, presc_b)
         `CHK("n_int_b", b ? 8'h7F : 8'h0D, n_int_b)
         `CHK("n_int", b ? 8'h7F : 8'h0D, n_int)
         `CHK("frac", w[POS_FRAC +: 11], frac)
         `CHK("def_sel", w[POS_DEF], def_sel)
      end
      for (int k = 0; k < 4; k++) begin
         wr({k[1:0], RST_PUMP[21:0]});
         `CHK("pump_sel", k[1:0], pump_sel)
         wr(mk_bw(2'h0, k[1:0], 1'b1, ~k[1:0]));
         `CHK("crit", k[1:0], crit)
         `CHK("vco", ~k[1:0], vco_dynamic_current)
         w = mk_ctrl(k[1:0] % 2'h3, k[0], SPUR_OFF, k[1:0], k[0], k[1]);
         wr(w);
         `CHK("ctrl", w, ctrl_w)
         `CHK("if_sel", k[1:0] % 2'h3, if_sel)
         `CHK("ref_sel", k[0], ref_sel)
         `CHK("pwr", k[1:0], pwr)
         `CHK("rf_on", k[0], rf_on)
         `CHK("if_on", k[1], if_on)
      end
      // an address outside the bank must leave the control and bandwidth words alone
      w = ctrl_w;
      wr(24'hABCDE7);
      `CHK("ctrl", w, ctrl_w)
      `CHK("bw", mk_bw(2'h0, 2'h3, 1'b1, 2'h0), bw_w)
      // chip enable overrides the software enables
      i_chip_enable <= 1'b0;
      repeat (6) @(posedge i_clk);
      `CHK("rf_on", 1'b0, rf_on)
      `CHK("if_on", 1'b0, if_on)
      i_chip_enable <= 1'b1;
      repeat (6) @(posedge i_clk);
      `CHK("rf_on", 1'b1, rf_on)
      // bandwidth controller: disable, timed run, early stop on phase
      wr(mk_bw(2'h0, 2'h0, 1'b0, 2'h3));
      `CHK("bw_act", 1'b0, bw_act)
      wr(mk_bw(2'h0, 2'h0, 1'b1, 2'h3));
      `CHK("bw_act", 1'b1, bw_act)
      for (t = 0; t < 600 && bw_act !== 1'b0; t++) @(posedge i_clk);
      `CHK("bandwidth_duration", 1'b1, (t > 30 && t < 70))
      wr(mk_bw(2'h3, 2'h0, 1'b0, 2'h3));
      wr(mk_bw(2'h3, 2'h0, 1'b1, 2'h3));
      repeat (100) @(posedge i_clk);
      `CHK("bw_act", 1'b1, bw_act)
      i_phase_ok <= 1'b1;
      repeat (5) @(posedge i_clk);
      `CHK("bw_act", 1'b0, bw_act)
      i_phase_ok <= 1'b0;
      // spur compensation: one-time freezes on lock, tracking keeps going
      wr(mk_ctrl(2'h0, 1'b0, SPUR_ONCE, 2'h0, 1'b1, 1'b1));
      `CHK("spur", 1'b1, spur_tr)
      i_locked <= 1'b1;
      repeat (5) @(posedge i_clk);
      `CHK("spur", 1'b0, spur_tr)
      wr(mk_ctrl(2'h0, 1'b0, SPUR_TRACK, 2'h0, 1'b1, 1'b1));
      `CHK("spur", 1'b1, spur_tr)
      wr(mk_ctrl(2'h0, 1'b0, SPUR_OFF, 2'h0, 1'b1, 1'b1));
      `CHK("spur", 1'b0, spur_tr)
      // bring-up on built-in IF counters: bandwidth word first, main word last
      wr(mk_bw(2'h0, 2'h0, 1'b1, 2'h3));
      wr({2'h1, RST_PUMP[21:0]});
      wr(mk_ctrl(2'h2, 1'b0, SPUR_TRACK, 2'h3, 1'b1, 1'b1));
      w = {1'b1, 1'b0, 2'b00, 4'h9, 3'h2, 11'h123, 2'b00};
      wr(w);
      `CHK("main", w, main_w)
      `CHK("def_sel", 1'b1, def_sel)
      `CHK("n_int", 8'h38, n_int)
      `CHK("n_int_b", 8'h38, n_int_b)
      `CHK("pump_sel", 2'h1, pump_sel)
      `CHK("if_sel", 2'h2, if_sel)
      `CHK("pwr", 2'h3, pwr)
      `CHK("vco", 2'h3, vco_dynamic_current)
      conclude();
   end
endmodule : tb_top
